/* File: seq_pkg.sv */
package seq_pkg;
   // ==========================================
   // Sequencer states
   typedef enum logic [2:0] {
      ST_HARD_RESET = 3'b000,
      ST_CFG_INIT = 3'b001,
      ST_INIT_FAILED = 3'b010,
      ST_INIT_RESET = 3'b011,
      ST_SELF_TEST = 3'b100,
      ST_FAILED = 3'b101,
      ST_PASSED = 3'b110,
      ST_SOFT_RESET = 3'b111
   } seq_state_t;

   // ==========================================
   // Timing
   localparam int CLK_HZ = 125_000_000;
   localparam int BUDGET_MS = 4900;
   // Longest time rounds down
   localparam longint BUDGET_CYC = (longint'(BUDGET_MS) * CLK_HZ) / 1000;
   localparam int CNT_W = 30;

   // ==========================================
   // Reset values of status and control bits
   localparam logic PASSED_RST = 1'b0;
   localparam logic READY_RST = 1'b0;
   localparam logic RST_BIT_RST = 1'b0;
   localparam logic INHIBIT_RST = 1'b0;
endpackage : seq_pkg

/* File: budget_timer.sv */
`timescale 1ns/1ps
// ==========================================
// Completion budget timer
module budget_timer
   import seq_pkg::*;
#(
   parameter logic [CNT_W-1:0] LIMIT = CNT_W'(BUDGET_CYC)
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic restart,
   input wire logic run,
   output logic expired
);
   logic [CNT_W-1:0] cnt_ff; // Cycles with run high since restart, held at LIMIT

   // Count while running, restart on request
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
      end else if (restart) begin
         cnt_ff <= '0;
      end else if (run && cnt_ff != LIMIT) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // Budget used up
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         expired <= 1'b0;
      end else if (restart) begin
         expired <= 1'b0;
      end else begin
         expired <= run && (cnt_ff == LIMIT);
      end
   end
endmodule : budget_timer

/* File: selftest_init_sequencer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Line low: hard reset, fail line asserted.
// - Config init loads registers, keeps failure shown.
// - Init plus self test within 4.9 s.
// - Before access opens: passed 0, ready 1.
// - Closed-access init failure waits for hard reset.
// - Identity loads before or after access opens.
// - Self test: passed 0, ready 0, fail asserted.
// - Self test/soft reset accept only control bits.
// - Self test ends passed or failed.
// - Open-access init failure: init failed state.
// - Self test failure: failed state, reset exit.
// - Passed: passed 1, fail line released.
// - Soft reset: inactive, requests withdrawn.
// - Soft reset reads passed 0, ready 0.
// - Init reset: like soft, ready 1.
// - Catastrophic fault raises internal indication.
// - Fail line low iff passed 0, inhibit 0.
// - Line rising leaves hard reset to init.
// - Reset bit set/clear moves between states.
// - All five mandatory states are implemented.
// - Without sequence: no fail, passed never cleared.
// - Identity valid before entering self test.
// - Access stays open until hard reset.
// - Soft reset keeps address and accessibility.
// - Catastrophic fault may move to failed.
module selftest_init_sequencer
   import seq_pkg::*;
#(
   parameter bit HAS_CFG_INIT = 1'b1,
   parameter bit HAS_SEQUENCE = 1'b1,
   parameter logic [CNT_W-1:0] BUDGET_CYCLES = CNT_W'(BUDGET_CYC)
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic bus_sysreset_low,
   input wire logic reset_bit_wr,
   input wire logic reset_bit_val,
   input wire logic inhibit_wr,
   input wire logic inhibit_val,
   input wire logic cfg_access_open,
   input wire logic cfg_initialized,
   input wire logic cfg_init_fail,
   input wire logic ident_valid,
   input wire logic test_pass,
   input wire logic test_fail,
   input wire logic dead,
   input wire logic op_ready,
   output logic sysfail_o,
   output logic sysfail_oe,
   output logic failed_led_ff,
   output logic passed_ff,
   output logic ready_ff,
   output logic reset_bit_ff,
   output logic inhibit_ff,
   output logic cfg_access_ff,
   output logic load_cfg_ff,
   output logic run_test_ff,
   output logic active_ff,
   output logic withdraw_req_ff,
   output logic dead_flag_ff,
   output logic budget_over_ff,
   output seq_state_t state_ff
);
   // ==========================================
   // Pin synchronisers
   logic bus_sysreset_low_m_ff; // First stage, read only by second
   logic bus_sysreset_low_s_ff; // Synchronised line level
   logic bus_sysreset_low_d_ff; // Previous synchronised level
   logic rst_prev_ff; // Previous reset bit
   seq_state_t nxt_state;
   logic expired; // Budget used up
   logic timing; // Budget window active
   logic restart; // Budget restart pulse
   logic rst_rise;
   logic rst_fall;
   logic line_rise;

   // Bring bus reset line into the clock domain
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_sysreset_low_m_ff <= 1'b0;
         bus_sysreset_low_s_ff <= 1'b0;
         bus_sysreset_low_d_ff <= 1'b0;
      end else begin
         bus_sysreset_low_m_ff <= bus_sysreset_low;
         bus_sysreset_low_s_ff <= bus_sysreset_low_m_ff;
         bus_sysreset_low_d_ff <= bus_sysreset_low_s_ff;
      end
   end

   // ==========================================
   // Control bits written by the bus master
   // Reset bit may be written in all states while line high
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reset_bit_ff <= RST_BIT_RST;
      end else if (!bus_sysreset_low_s_ff) begin
         reset_bit_ff <= RST_BIT_RST; // Cleared in hard reset
      end else if (reset_bit_wr) begin
         reset_bit_ff <= reset_bit_val;
      end
   end

   // Failure driver inhibit bit
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         inhibit_ff <= INHIBIT_RST;
      end else if (!bus_sysreset_low_s_ff) begin
         inhibit_ff <= INHIBIT_RST;
      end else if (inhibit_wr) begin
         inhibit_ff <= inhibit_val;
      end
   end

   // Edge history of reset bit
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_prev_ff <= RST_BIT_RST;
      end else begin
         rst_prev_ff <= reset_bit_ff;
      end
   end

   assign rst_rise = reset_bit_ff && !rst_prev_ff;
   assign rst_fall = !reset_bit_ff && rst_prev_ff;
   assign line_rise = bus_sysreset_low_s_ff && !bus_sysreset_low_d_ff;

   // ==========================================
   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_HARD_RESET: begin
            if (line_rise) begin
               nxt_state = HAS_CFG_INIT ? ST_CFG_INIT : ST_SELF_TEST;
            end
         end
         ST_CFG_INIT: begin
            if (cfg_init_fail && cfg_access_ff) begin
               nxt_state = ST_INIT_FAILED;
            end else if (cfg_init_fail || expired) begin
               // Closed access: stay until hard reset
               nxt_state = cfg_access_ff ? ST_INIT_FAILED : ST_CFG_INIT;
            end else if (cfg_initialized && ident_valid) begin
               nxt_state = ST_SELF_TEST;
            end
         end
         ST_INIT_FAILED: begin
            if (reset_bit_ff) begin
               nxt_state = ST_INIT_RESET;
            end
         end
         ST_INIT_RESET: begin
            if (rst_fall || !reset_bit_ff) begin
               nxt_state = ST_CFG_INIT;
            end
         end
         ST_SELF_TEST: begin
            if (reset_bit_ff) begin
               nxt_state = ST_SOFT_RESET;
            end else if (test_fail || expired) begin
               nxt_state = ST_FAILED;
            end else if (test_pass) begin
               nxt_state = ST_PASSED;
            end
         end
         ST_FAILED: begin
            if (reset_bit_ff) begin
               nxt_state = ST_SOFT_RESET;
            end
         end
         ST_PASSED: begin
            if (reset_bit_ff) begin
               nxt_state = ST_SOFT_RESET;
            end else if (dead) begin
               nxt_state = ST_FAILED;
            end
         end
         ST_SOFT_RESET: begin
            if (!reset_bit_ff) begin
               nxt_state = ST_SELF_TEST;
            end
         end
         default: nxt_state = ST_HARD_RESET;
      endcase
   end

   // State register; the line low forces hard reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= ST_HARD_RESET;
      end else if (!bus_sysreset_low_s_ff) begin
         state_ff <= ST_HARD_RESET;
      end else if (!HAS_SEQUENCE) begin
         state_ff <= ST_PASSED;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================
   // Completion budget
   assign timing = (state_ff == ST_CFG_INIT) || (state_ff == ST_SELF_TEST);
   assign restart = line_rise || rst_fall;

   budget_timer #(
      .LIMIT(BUDGET_CYCLES)
   ) u_budget (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .restart(restart),
      .run(timing),
      .expired(expired)
   );

   // Sticky overrun flag, set wins over clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         budget_over_ff <= 1'b0;
      end else if (expired) begin
         budget_over_ff <= 1'b1;
      end else if (restart) begin
         budget_over_ff <= 1'b0;
      end
   end

   // ==========================================
   // Status bits from next state
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         passed_ff <= PASSED_RST;
         ready_ff <= READY_RST;
      end else if (!HAS_SEQUENCE) begin
         passed_ff <= 1'b1;
         ready_ff <= op_ready;
      end else if (!bus_sysreset_low_s_ff) begin
         passed_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         case (nxt_state)
            ST_CFG_INIT, ST_INIT_FAILED, ST_INIT_RESET: begin
               passed_ff <= 1'b0;
               ready_ff <= 1'b1;
            end
            ST_PASSED: begin
               passed_ff <= 1'b1;
               ready_ff <= op_ready;
            end
            default: begin
               passed_ff <= 1'b0;
               ready_ff <= 1'b0;
            end
         endcase
      end
   end

   // Failure driver from passed and inhibit, LED from passed alone
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sysfail_oe <= 1'b1;
         failed_led_ff <= 1'b1;
      end else if (!HAS_SEQUENCE) begin
         sysfail_oe <= 1'b0;
         failed_led_ff <= 1'b0;
      end else begin
         sysfail_oe <= !passed_ff && !inhibit_ff;
         failed_led_ff <= !passed_ff;
      end
   end

   // Open-collector: only ever drives low
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sysfail_o <= 1'b0;
      end else begin
         sysfail_o <= 1'b0;
      end
   end

   // ==========================================
   // Register access: opens once, stays until hard reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_access_ff <= 1'b0;
      end else if (!bus_sysreset_low_s_ff) begin
         cfg_access_ff <= 1'b0;
      end else if (!HAS_CFG_INIT && line_rise) begin
         cfg_access_ff <= 1'b1;
      end else if (cfg_access_open && state_ff == ST_CFG_INIT) begin
         cfg_access_ff <= 1'b1;
      end
   end

   // Configuration load strobe level and self test run level
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_cfg_ff <= 1'b0;
         run_test_ff <= 1'b0;
      end else begin
         load_cfg_ff <= nxt_state == ST_CFG_INIT && bus_sysreset_low_s_ff;
         run_test_ff <= nxt_state == ST_SELF_TEST && bus_sysreset_low_s_ff;
      end
   end

   // Activity; soft and init reset withdraw requests
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_ff <= 1'b0;
         withdraw_req_ff <= 1'b1;
      end else begin
         active_ff <= bus_sysreset_low_s_ff && nxt_state == ST_PASSED;
         withdraw_req_ff <= !(bus_sysreset_low_s_ff && nxt_state == ST_PASSED);
      end
   end

   // Catastrophic fault indication, sticky to hard reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dead_flag_ff <= 1'b0;
      end else if (dead && state_ff == ST_PASSED) begin
         dead_flag_ff <= 1'b1;
      end else if (!bus_sysreset_low_s_ff) begin
         dead_flag_ff <= 1'b0;
      end
   end
endmodule : selftest_init_sequencer

/* File: selftest_init_sequencer_chk.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker for the init sequencer
module selftest_init_sequencer_chk
   import seq_pkg::*;
#(
   parameter logic [CNT_W-1:0] BUDGET_CYCLES = CNT_W'(BUDGET_CYC)
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic bus_sysreset_low,
   input wire logic reset_bit_wr,
   input wire logic reset_bit_val,
   input wire logic inhibit_wr,
   input wire logic inhibit_val,
   input wire logic test_pass,
   input wire logic test_fail,
   input wire logic dead,
   input wire logic sysfail_o,
   input wire logic sysfail_oe,
   input wire logic failed_led_ff,
   input wire logic passed_ff,
   input wire logic ready_ff,
   input wire logic reset_bit_ff,
   input wire logic inhibit_ff,
   input wire logic cfg_access_ff,
   input wire logic active_ff,
   input wire logic withdraw_req_ff,
   input wire logic dead_flag_ff,
   input seq_state_t state_ff
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [CNT_W-1:0] st_cnt_ff; // Cycles spent in self test
   // Count the self test stay so the budget can be bounded
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) st_cnt_ff <= '0;
      else if (state_ff == ST_SELF_TEST) st_cnt_ff <= st_cnt_ff + 1'b1;
      else st_cnt_ff <= '0;
   end
   // Pin has been high long enough for the synchroniser to agree
   sequence s_pin_up; bus_sysreset_low [*3]; endsequence
   sequence s_set; s_pin_up ##0 $rose(reset_bit_ff) ##0 state_ff inside {ST_SELF_TEST, ST_PASSED, ST_FAILED}; endsequence
   sequence s_clr; s_pin_up ##0 $fell(reset_bit_ff) ##0 state_ff == ST_SOFT_RESET; endsequence
   property p_hard; !bus_sysreset_low [*4] |-> state_ff == ST_HARD_RESET; endproperty
   a_hard: assert property (p_hard) else $error("pin low without hard reset");
   property p_drv; 1'b1 |=> sysfail_oe == (!$past(passed_ff) && !$past(inhibit_ff)) && !sysfail_o; endproperty
   a_drv: assert property (p_drv) else $error("failure driver wrong");
   property p_led; 1'b1 |=> failed_led_ff == !$past(passed_ff); endproperty
   a_led: assert property (p_led) else $error("failed lamp wrong");
   property p_cfg; state_ff inside {ST_CFG_INIT, ST_INIT_FAILED, ST_INIT_RESET} |-> !passed_ff && ready_ff; endproperty
   a_cfg: assert property (p_cfg) else $error("init status bits wrong");
   property p_low; state_ff inside {ST_SELF_TEST, ST_FAILED, ST_SOFT_RESET} |-> !passed_ff && !ready_ff; endproperty
   a_low: assert property (p_low) else $error("test status bits wrong");
   property p_pass; state_ff == ST_PASSED |-> passed_ff && active_ff && !withdraw_req_ff; endproperty
   a_pass: assert property (p_pass) else $error("passed outputs wrong");
   property p_soft; state_ff == ST_SOFT_RESET |-> withdraw_req_ff && !active_ff; endproperty
   a_soft: assert property (p_soft) else $error("soft reset not quiet");
   property p_wr; s_pin_up ##0 reset_bit_wr |=> reset_bit_ff == $past(reset_bit_val); endproperty
   a_wr: assert property (p_wr) else $error("reset bit write lost");
   property p_inh; s_pin_up ##0 inhibit_wr |=> inhibit_ff == $past(inhibit_val); endproperty
   a_inh: assert property (p_inh) else $error("inhibit write lost");
   property p_set; s_set |=> state_ff == ST_SOFT_RESET; endproperty
   a_set: assert property (p_set) else $error("no soft reset entry");
   property p_clr; s_clr |=> state_ff == ST_SELF_TEST; endproperty
   a_clr: assert property (p_clr) else $error("no restart of test");
   property p_test; s_pin_up ##0 state_ff == ST_SELF_TEST && test_pass && !test_fail && !reset_bit_ff |=> state_ff == ST_PASSED; endproperty
   a_test: assert property (p_test) else $error("pass not taken");
   property p_dead; s_pin_up ##0 state_ff == ST_PASSED && dead && !reset_bit_ff |=> state_ff == ST_FAILED ##[0:1] dead_flag_ff; endproperty
   a_dead: assert property (p_dead) else $error("fault not taken");
   property p_budget; st_cnt_ff <= BUDGET_CYCLES + 2; endproperty
   a_budget: assert property (p_budget) else $error("self test overran");
   property p_keep; s_pin_up ##0 cfg_access_ff |=> cfg_access_ff; endproperty
   a_keep: assert property (p_keep) else $error("register access dropped");
endmodule : selftest_init_sequencer_chk

bind selftest_init_sequencer selftest_init_sequencer_chk #(.BUDGET_CYCLES(BUDGET_CYCLES)) u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .bus_sysreset_low(bus_sysreset_low), .reset_bit_wr(reset_bit_wr),
   .reset_bit_val(reset_bit_val), .inhibit_wr(inhibit_wr), .inhibit_val(inhibit_val), .test_pass(test_pass),
   .test_fail(test_fail), .dead(dead), .sysfail_o(sysfail_o), .sysfail_oe(sysfail_oe), .failed_led_ff(failed_led_ff),
   .passed_ff(passed_ff), .ready_ff(ready_ff), .reset_bit_ff(reset_bit_ff), .inhibit_ff(inhibit_ff),
   .cfg_access_ff(cfg_access_ff), .active_ff(active_ff), .withdraw_req_ff(withdraw_req_ff),
   .dead_flag_ff(dead_flag_ff), .state_ff(state_ff));

/* File: sys_ctrl_model.sv */
`timescale 1ns/1ps
// ==========================================
// System controller and commanding master
module sys_ctrl_model (
   input wire logic core_clk,
   output logic bus_sysreset_low,
   output logic reset_bit_wr,
   output logic reset_bit_val,
   output logic inhibit_wr,
   output logic inhibit_val
);
   // Power on with the reset line held low
   initial begin
      bus_sysreset_low = 1'b0;
      reset_bit_wr = 1'b0;
      reset_bit_val = 1'b1;
      inhibit_wr = 1'b0;
      inhibit_val = 1'b1;
   end
   // Drive the reset line level
   task set_pin(input logic v);
      @(negedge core_clk);
      bus_sysreset_low = v;
   endtask : set_pin
   // One write pulse; sel high picks the inhibit bit
   task write_bit(input logic sel, input logic v);
      @(negedge core_clk);
      if (sel) begin
         inhibit_wr = 1'b1;
         inhibit_val = v;
      end else begin
         reset_bit_wr = 1'b1;
         reset_bit_val = v;
      end
      @(negedge core_clk);
      reset_bit_wr = 1'b0;
      inhibit_wr = 1'b0;
      // Data no longer valid, so show the inverse
      reset_bit_val = ~reset_bit_val;
      inhibit_val = ~inhibit_val;
   endtask : write_bit
endmodule : sys_ctrl_model

/* File: selftest_init_sequencer_tb.sv */
`timescale 1ns/1ps
// ==========================================
// Testbench for the init sequencer
module selftest_init_sequencer_tb;
   import seq_pkg::*;
   localparam logic [CNT_W-1:0] BUDGET = 30'h0000_0032; // Short budget for simulation
   logic core_clk, sys_rst, bus_sysreset_low, reset_bit_wr, reset_bit_val, inhibit_wr, inhibit_val;
   logic cfg_access_open, cfg_initialized, cfg_init_fail, ident_valid, test_pass, test_fail, dead, op_ready;
   logic sysfail_o, sysfail_oe, failed_led_ff, passed_ff, ready_ff, reset_bit_ff, inhibit_ff, cfg_access_ff;
   logic load_cfg_ff, run_test_ff, active_ff, withdraw_req_ff, dead_flag_ff, budget_over_ff;
   seq_state_t state_ff;
   int fails, total_checks, cyc;
   selftest_init_sequencer #(.BUDGET_CYCLES(BUDGET)) dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .bus_sysreset_low(bus_sysreset_low), .reset_bit_wr(reset_bit_wr),
      .reset_bit_val(reset_bit_val), .inhibit_wr(inhibit_wr), .inhibit_val(inhibit_val),
      .cfg_access_open(cfg_access_open), .cfg_initialized(cfg_initialized), .cfg_init_fail(cfg_init_fail),
      .ident_valid(ident_valid), .test_pass(test_pass), .test_fail(test_fail), .dead(dead), .op_ready(op_ready),
      .sysfail_o(sysfail_o), .sysfail_oe(sysfail_oe), .failed_led_ff(failed_led_ff), .passed_ff(passed_ff),
      .ready_ff(ready_ff), .reset_bit_ff(reset_bit_ff), .inhibit_ff(inhibit_ff), .cfg_access_ff(cfg_access_ff),
      .load_cfg_ff(load_cfg_ff), .run_test_ff(run_test_ff), .active_ff(active_ff),
      .withdraw_req_ff(withdraw_req_ff), .dead_flag_ff(dead_flag_ff), .budget_over_ff(budget_over_ff),
      .state_ff(state_ff));
   sys_ctrl_model mdl (.core_clk(core_clk), .bus_sysreset_low(bus_sysreset_low), .reset_bit_wr(reset_bit_wr),
      .reset_bit_val(reset_bit_val), .inhibit_wr(inhibit_wr), .inhibit_val(inhibit_val));
   // 125 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Compare and count
   task chk(input string what, input logic [2:0] exp, input logic [2:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // Bounded wait for a state, then compare
   task wait_st(input seq_state_t s);
      int n;
      n = 0;
      while (state_ff !== s && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      chk("state", s, state_ff);
   endtask : wait_st
   // Pass a run of negative edges
   task tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   // Soft reset pulse followed by a fresh self test
   task restart_test;
      mdl.write_bit(1'b0, 1'b1);
      mdl.write_bit(1'b0, 1'b0);
      wait_st(ST_SELF_TEST);
   endtask : restart_test
   // Verdict and end of run
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // Hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         close_out();
      end
   end
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {cfg_access_open, cfg_initialized, cfg_init_fail, ident_valid} = 4'h0;
      {test_pass, test_fail, dead, op_ready} = 4'h0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      tick(2);
      chk("hard oe led rdy", 3'b110, {sysfail_oe, failed_led_ff, ready_ff});
      mdl.set_pin(1'b1);
      wait_st(ST_CFG_INIT);
      chk("pass rdy", 3'b001, {passed_ff, ready_ff});
      chk("load oe", 3'b011, {load_cfg_ff, sysfail_oe});
      {cfg_access_open, cfg_initialized, ident_valid} = 3'b111;
      wait_st(ST_SELF_TEST);
      chk("pass rdy run", 3'b001, {passed_ff, ready_ff, run_test_ff});
      test_pass = 1'b1;
      wait_st(ST_PASSED);
      test_pass = 1'b0;
      tick(1);
      chk("oe led pass", 3'b001, {sysfail_oe, failed_led_ff, passed_ff});
      op_ready = 1'b1;
      tick(2);
      chk("rdy access", 3'b011, {ready_ff, cfg_access_ff});
      $display("test power_up done");
      mdl.write_bit(1'b0, 1'b1);
      wait_st(ST_SOFT_RESET);
      chk("pass rdy wdraw", 3'b001, {passed_ff, ready_ff, withdraw_req_ff});
      chk("access", 3'b001, cfg_access_ff);
      mdl.write_bit(1'b1, 1'b1);
      tick(2);
      chk("inhibited oe led", 3'b001, {sysfail_oe, failed_led_ff});
      mdl.write_bit(1'b1, 1'b0);
      mdl.write_bit(1'b0, 1'b0);
      wait_st(ST_SELF_TEST);
      test_fail = 1'b1;
      wait_st(ST_FAILED);
      test_fail = 1'b0;
      tick(2);
      chk("fail pass rdy oe", 3'b001, {passed_ff, ready_ff, sysfail_oe});
      $display("test soft_reset done");
      restart_test();
      wait_st(ST_FAILED);
      chk("budget over", 3'b001, budget_over_ff);
      $display("test budget done");
      restart_test();
      test_pass = 1'b1;
      wait_st(ST_PASSED);
      test_pass = 1'b0;
      dead = 1'b1;
      wait_st(ST_FAILED);
      dead = 1'b0;
      chk("dead flag", 3'b001, dead_flag_ff);
      $display("test fault done");
      mdl.set_pin(1'b0);
      wait_st(ST_HARD_RESET);
      {cfg_access_open, cfg_initialized, ident_valid} = 3'b000;
      mdl.set_pin(1'b1);
      wait_st(ST_CFG_INIT);
      cfg_init_fail = 1'b1;
      tick(60);
      chk("closed state", ST_CFG_INIT, state_ff);
      chk("closed access", 3'b000, cfg_access_ff);
      mdl.set_pin(1'b0);
      wait_st(ST_HARD_RESET);
      cfg_init_fail = 1'b0;
      mdl.set_pin(1'b1);
      wait_st(ST_CFG_INIT);
      cfg_access_open = 1'b1;
      tick(2);
      cfg_init_fail = 1'b1;
      wait_st(ST_INIT_FAILED);
      cfg_init_fail = 1'b0;
      tick(1);
      chk("pass rdy oe", 3'b011, {passed_ff, ready_ff, sysfail_oe});
      mdl.write_bit(1'b0, 1'b1);
      wait_st(ST_INIT_RESET);
      chk("pass rdy", 3'b001, {passed_ff, ready_ff});
      mdl.write_bit(1'b0, 1'b0);
      wait_st(ST_CFG_INIT);
      $display("test init_fail done");
      close_out();
   end
endmodule : selftest_init_sequencer_tb
